// ### verilog/sfcfe_defines.svh
// Constants for the serial flash command front end.
`ifndef SFCFE_DEFINES_SVH
`define SFCFE_DEFINES_SVH
`define SFCFE_OPCODE_BITS      8
`define SFCFE_ADDR_BITS        24
`define SFCFE_FRAME_BITS       32
`define SFCFE_OP_RD_CONT_LEG   8'hE8
`define SFCFE_OP_RD_CONT_HF    8'h0B
`define SFCFE_OP_RD_CONT_LF    8'h03
`define SFCFE_OP_RD_PAGE       8'hD2
`define SFCFE_OP_RD_BUF1       8'hD4
`define SFCFE_OP_RD_BUF2       8'hD6
`define SFCFE_OP_PROG_BUF1     8'h83
`define SFCFE_OP_PROG_BUF2     8'h86
`define SFCFE_OP_PROG_THRU1    8'h82
`define SFCFE_OP_PROG_THRU2    8'h85
`define SFCFE_OP_ERASE_PAGE    8'h81
`define SFCFE_OP_ERASE_BLOCK   8'h50
`define SFCFE_OP_ERASE_SECTOR  8'h7C
`define SFCFE_OP_ERASE_CHIP    8'hC7
`define SFCFE_OP_XFER_BUF1     8'h53
`define SFCFE_OP_XFER_BUF2     8'h55
`define SFCFE_OP_CMP_BUF1      8'h60
`define SFCFE_OP_CMP_BUF2      8'h61
`define SFCFE_OP_PROT_PREFIX   8'h3D
`define SFCFE_OP_STATUS        8'hD7
`define SFCFE_PAGE_BITS        13
`define SFCFE_BYTE_BITS_528    10
`define SFCFE_BYTE_BITS_512    9
`define SFCFE_PAGE_LSB_528     10
`define SFCFE_PAGE_LSB_512     9
`define SFCFE_BUSY_CYCLES      16'h0100
`endif

// ### verilog/sfcfe_pkg.sv
// Types for the serial flash command front end.
package sfcfe_pkg;
  typedef enum logic [1:0] {
    SFCFE_SRC_NONE = 2'b00,
    SFCFE_SRC_MAIN = 2'b01,
    SFCFE_SRC_BUF1 = 2'b10,
    SFCFE_SRC_BUF2 = 2'b11
  } sfcfe_src_t;
  typedef enum logic [2:0] {
    SFCFE_OP_NONE   = 3'b000,
    SFCFE_OP_READ   = 3'b001,
    SFCFE_OP_PROG   = 3'b010,
    SFCFE_OP_ERASE  = 3'b011,
    SFCFE_OP_XFER   = 3'b100,
    SFCFE_OP_CMP    = 3'b101,
    SFCFE_OP_PROT   = 3'b110,
    SFCFE_OP_OTHER  = 3'b111
  } sfcfe_kind_t;
  typedef enum logic [2:0] {
    SFCFE_ER_NONE   = 3'b000,
    SFCFE_ER_PAGE   = 3'b001,
    SFCFE_ER_BLOCK  = 3'b010,
    SFCFE_ER_SECTOR = 3'b011,
    SFCFE_ER_CHIP   = 3'b100
  } sfcfe_erase_t;
  typedef enum logic [1:0] {
    SFCFE_ST_IDLE = 2'b00,
    SFCFE_ST_BUSY = 2'b01
  } sfcfe_state_t;
endpackage : sfcfe_pkg

// ### verilog/sfcfe_top.sv
// Serial flash command front end: link shifter, opcode decode, busy timing.
`timescale 1ns/10ps
`default_nettype none
`include "sfcfe_defines.svh"
module sfcfe_top
  import sfcfe_pkg::*;
#(
  parameter int BUSY_CYCLES = `SFCFE_BUSY_CYCLES
) (
  input  wire logic        CORE_CLK,        // Core clock, 100 MHz.
  input  wire logic        SYS_RST,         // Internal power-on reset, active high.
  input  wire logic        SCK,             // Serial clock from host.
  input  wire logic        CS_N,            // Chip select, active low.
  input  wire logic        SI,              // Serial data in.
  output logic             SO,              // Serial data out.
  output logic             SO_OE,           // Serial out drive enable.
  input  wire logic        WP_N,            // Write protect, active low.
  input  wire logic        RESET_N,         // Reset pin, active low.
  output logic             RDY_BUSY_O,      // Ready/busy pin output value.
  output logic             RDY_BUSY_OE,     // Ready/busy drive enable.
  input  wire logic        PAGE_512,        // Page size is 512 bytes when high.
  input  wire logic [7:0]  RD_DATA,         // Byte to send during reads.
  output logic             CMD_VALID,       // Accepted command pulse.
  output logic [7:0]       CMD_OPCODE,      // Accepted opcode.
  output logic [2:0]       CMD_KIND,        // Command class.
  output logic [1:0]       CMD_SRC,         // Read source.
  output logic [2:0]       CMD_ERASE,       // Erase granularity.
  output logic [12:0]      CMD_PAGE,        // Page select field.
  output logic [9:0]       CMD_BYTE,        // Byte within page field.
  output logic             CMD_DROPPED      // Protected command discarded pulse.
);

  // Link domain: shifter on SCK rising edge, held reset while deselected.
  logic        link_rst;
  logic [5:0]  bit_cnt;
  logic [31:0] shift_in;
  logic        frame_tgl;
  logic [31:0] frame_word;
  logic [7:0]  out_byte;
  logic [2:0]  out_bit;

  assign link_rst = CS_N | ~RESET_N | SYS_RST;

  always_ff @(posedge SCK or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt  <= 6'h00;
      shift_in <= 32'h0000_0000;
    end else begin
      shift_in <= {shift_in[30:0], SI};
      if (bit_cnt != 6'h3F) begin
        bit_cnt <= bit_cnt + 6'h01;
      end
    end
  end

  // A frame word is captured once the opcode and 24 address bits are in.
  logic frame_done;
  assign frame_done = (bit_cnt == 6'(`SFCFE_FRAME_BITS - 1));

  always_ff @(posedge SCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      frame_tgl  <= 1'b0;
      frame_word <= 32'h0000_0000;
    end else if (!CS_N && frame_done) begin
      frame_tgl  <= ~frame_tgl;
      frame_word <= {shift_in[30:0], SI};
    end
  end

  // Output shifts on the falling edge, MSB first, a new byte after every eighth input bit.
  // A falling edge before the first rising edge, as in mode 3, is not counted.
  always_ff @(negedge SCK or posedge link_rst) begin
    if (link_rst) begin
      out_bit  <= 3'h7;
      out_byte <= 8'h00;
    end else if (bit_cnt != 6'h00) begin
      if (out_bit == 3'h0) begin
        out_byte <= RD_DATA;
        out_bit  <= 3'h7;
      end else begin
        out_bit <= out_bit - 3'h1;
      end
    end
  end

  assign SO    = out_byte[out_bit];
  assign SO_OE = ~CS_N;

  // Core domain: three-stage synchronisers for the frame toggle and pins.
  logic [2:0] tgl_sync;
  logic [2:0] wp_sync;
  logic [2:0] rst_sync;
  logic [2:0] cs_sync;
  logic       tgl_seen;
  logic       wp_n_q;
  logic       rst_n_q;
  logic       cs_n_q;

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tgl_sync <= 3'b000;
      wp_sync  <= 3'b111;
      rst_sync <= 3'b111;
      cs_sync  <= 3'b111;
    end else begin
      tgl_sync <= {tgl_sync[1:0], frame_tgl};
      wp_sync  <= {wp_sync[1:0], WP_N};
      rst_sync <= {rst_sync[1:0], RESET_N};
      cs_sync  <= {cs_sync[1:0], CS_N};
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tgl_seen <= 1'b0;
      wp_n_q   <= 1'b1;
      rst_n_q  <= 1'b1;
      cs_n_q   <= 1'b1;
    end else begin
      if (tgl_sync[1] == tgl_sync[2]) tgl_seen <= tgl_sync[2];
      if (wp_sync[1] == wp_sync[2]) wp_n_q <= wp_sync[2];
      if (rst_sync[1] == rst_sync[2]) rst_n_q <= rst_sync[2];
      if (cs_sync[1] == cs_sync[2]) cs_n_q <= cs_sync[2];
    end
  end

  logic new_frame;
  assign new_frame = (tgl_sync[2] == tgl_sync[1]) && (tgl_sync[2] != tgl_seen);

  // The frame word is stable from the toggle until the next frame end.
  logic [7:0]  op;
  logic [23:0] addr;
  assign op   = frame_word[31:24];
  assign addr = frame_word[23:0];

  function automatic sfcfe_kind_t op_kind(input logic [7:0] o);
    unique case (o)
      `SFCFE_OP_RD_CONT_LEG, `SFCFE_OP_RD_CONT_HF, `SFCFE_OP_RD_CONT_LF,
      `SFCFE_OP_RD_PAGE, `SFCFE_OP_RD_BUF1, `SFCFE_OP_RD_BUF2: op_kind = SFCFE_OP_READ;
      `SFCFE_OP_PROG_BUF1, `SFCFE_OP_PROG_BUF2,
      `SFCFE_OP_PROG_THRU1, `SFCFE_OP_PROG_THRU2: op_kind = SFCFE_OP_PROG;
      `SFCFE_OP_ERASE_PAGE, `SFCFE_OP_ERASE_BLOCK,
      `SFCFE_OP_ERASE_SECTOR, `SFCFE_OP_ERASE_CHIP: op_kind = SFCFE_OP_ERASE;
      `SFCFE_OP_XFER_BUF1, `SFCFE_OP_XFER_BUF2: op_kind = SFCFE_OP_XFER;
      `SFCFE_OP_CMP_BUF1, `SFCFE_OP_CMP_BUF2: op_kind = SFCFE_OP_CMP;
      `SFCFE_OP_PROT_PREFIX: op_kind = SFCFE_OP_PROT;
      default: op_kind = SFCFE_OP_OTHER;
    endcase
  endfunction : op_kind

  sfcfe_kind_t  kind;
  sfcfe_src_t   src;
  sfcfe_erase_t erase;
  assign kind = op_kind(op);

  assign src = (op == `SFCFE_OP_RD_BUF1) ? SFCFE_SRC_BUF1 :
               (op == `SFCFE_OP_RD_BUF2) ? SFCFE_SRC_BUF2 :
               (kind == SFCFE_OP_READ)  ? SFCFE_SRC_MAIN : SFCFE_SRC_NONE;

  assign erase = (op == `SFCFE_OP_ERASE_PAGE)   ? SFCFE_ER_PAGE :
                 (op == `SFCFE_OP_ERASE_BLOCK)  ? SFCFE_ER_BLOCK :
                 (op == `SFCFE_OP_ERASE_SECTOR) ? SFCFE_ER_SECTOR :
                 (op == `SFCFE_OP_ERASE_CHIP)   ? SFCFE_ER_CHIP : SFCFE_ER_NONE;

  // Address fields per page size.
  logic [12:0] page_fld;
  logic [9:0]  byte_fld;
  assign page_fld = PAGE_512 ? addr[`SFCFE_PAGE_LSB_512 +: `SFCFE_PAGE_BITS]
                             : addr[`SFCFE_PAGE_LSB_528 +: `SFCFE_PAGE_BITS];
  assign byte_fld = PAGE_512 ? {1'b0, addr[`SFCFE_BYTE_BITS_512-1:0]}
                             : addr[`SFCFE_BYTE_BITS_528-1:0];

  // Protection prefix commands pass under write-protect; protection register
  // writes (prefix with register-program tail) do not.
  logic prot_reg_write;
  logic prot_allowed;
  assign prot_reg_write = (kind == SFCFE_OP_PROT) && (addr[23:16] == 8'h2A)
                          && (addr[15:8] == 8'h7F) && (addr[7:0] == 8'hFC);
  assign prot_allowed   = (kind == SFCFE_OP_PROT) && !prot_reg_write;

  logic protected_cmd;
  assign protected_cmd = !wp_n_q && ((kind == SFCFE_OP_PROG) || (kind == SFCFE_OP_ERASE)
                                     || prot_reg_write);

  logic self_timed;
  assign self_timed = (kind == SFCFE_OP_PROG) || (kind == SFCFE_OP_ERASE)
                      || (kind == SFCFE_OP_XFER) || (kind == SFCFE_OP_CMP)
                      || prot_allowed || prot_reg_write;

  // Busy state machine; the reset pin aborts and holds it idle.
  sfcfe_state_t state;
  sfcfe_state_t next_state;
  logic [15:0]  busy_cnt;
  logic [15:0]  next_busy_cnt;
  logic         start_op;
  logic         pin_reset;
  logic         disc_pending;
  assign pin_reset = !rst_n_q;
  assign start_op  = new_frame && !pin_reset && (state == SFCFE_ST_IDLE)
                     && self_timed && !protected_cmd;

  always_comb begin
    next_state    = state;
    next_busy_cnt = busy_cnt;
    unique case (state)
      SFCFE_ST_IDLE: begin
        if (start_op) begin
          next_state    = SFCFE_ST_BUSY;
          next_busy_cnt = 16'(BUSY_CYCLES - 1);
        end
      end
      SFCFE_ST_BUSY: begin
        if (busy_cnt == 16'h0000) begin
          next_state = SFCFE_ST_IDLE;
        end else begin
          next_busy_cnt = busy_cnt - 16'h0001;
        end
      end
      default: begin
        next_state = SFCFE_ST_IDLE;
      end
    endcase
    if (pin_reset) begin
      next_state    = SFCFE_ST_IDLE;
      next_busy_cnt = 16'h0000;
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state    <= SFCFE_ST_IDLE;
      busy_cnt <= 16'h0000;
    end else begin
      state    <= next_state;
      busy_cnt <= next_busy_cnt;
    end
  end

  // A discarded command suppresses CMD_VALID until deselect or the reset pin; the busy machine is not held.
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      disc_pending <= 1'b0;
    end else if (new_frame && protected_cmd && !pin_reset) begin
      disc_pending <= 1'b1;
    end else if (cs_n_q || pin_reset) begin
      disc_pending <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      CMD_VALID   <= 1'b0;
      CMD_DROPPED <= 1'b0;
      CMD_OPCODE  <= 8'h00;
      CMD_KIND    <= 3'h0;
      CMD_SRC     <= 2'h0;
      CMD_ERASE   <= 3'h0;
      CMD_PAGE    <= 13'h0000;
      CMD_BYTE    <= 10'h000;
    end else begin
      CMD_VALID   <= new_frame && !pin_reset && !protected_cmd && !disc_pending;
      CMD_DROPPED <= new_frame && !pin_reset && protected_cmd;
      if (new_frame) begin
        CMD_OPCODE <= op;
        CMD_KIND   <= kind;
        CMD_SRC    <= src;
        CMD_ERASE  <= erase;
        CMD_PAGE   <= page_fld;
        CMD_BYTE   <= byte_fld;
      end
    end
  end

  assign RDY_BUSY_O  = 1'b0;
  assign RDY_BUSY_OE = (state == SFCFE_ST_BUSY);

endmodule : sfcfe_top
`default_nettype wire

// ### dv/sfcfe_host.sv
// Serial bus master model that frames commands for the front end.
`timescale 1ns/10ps
`default_nettype none
module sfcfe_host (
  output logic      sck,   // Serial clock, still outside frames.
  output logic      cs_n,  // Select, active low.
  output logic      si,    // Data toward the device.
  input  wire logic so,    // Data from the device.
  input  wire logic so_oe  // Device drives so when high.
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  task automatic frame(input logic [7:0] op, input logic [23:0] addr, input logic [5:0] n,
                       input logic mode3, output logic [7:0] rx);
    logic [39:0] bits;
    bits = {op, addr, 8'h00};
    rx = 8'h00;
    sck = mode3;
    #40 cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      sck = 1'b0;
      si = bits[39-i];
      #40 sck = 1'b1;
      if (i >= 32) rx = {rx[6:0], so_oe ? so : 1'bx};
      #40;
    end
    sck = mode3;
    #40 cs_n = 1'b1;
    si = ~si;  // A released line does not keep its last level.
  endtask : frame
endmodule : sfcfe_host
`default_nettype wire

// ### dv/sfcfe_checker.sv
// Concurrent checks on the command front end ports.
`timescale 1ns/10ps
`default_nettype none
module sfcfe_checker
  import sfcfe_pkg::*;
#(
  parameter int BUSY_CYCLES = 256
) (
  input wire logic CORE_CLK, SYS_RST, CS_N, SO_OE, RESET_N, RDY_BUSY_O, RDY_BUSY_OE,
  input wire logic PAGE_512, CMD_VALID, CMD_DROPPED,
  input wire logic [2:0] CMD_KIND, CMD_ERASE,
  input wire logic [1:0] CMD_SRC,
  input wire logic [9:0] CMD_BYTE
);
  logic [15:0] busy_cnt;
  logic        rst_seen;
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      busy_cnt <= 16'h0000;
      rst_seen <= 1'b0;
    end else begin
      busy_cnt <= RDY_BUSY_OE ? busy_cnt + 16'h0001 : 16'h0000;
      rst_seen <= RDY_BUSY_OE ? (rst_seen | !RESET_N) : !RESET_N;
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_pin_reset; !RESET_N [*8]; endsequence
  sequence s_busy_cmd;
    CMD_VALID && CMD_KIND inside {3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
  endsequence
  a_so_float: assert property (SO_OE == !CS_N) else $error("so enable wrong");
  a_pin_low: assert property (RDY_BUSY_O == 1'b0) else $error("busy pin level");
  a_busy_start: assert property (s_busy_cmd |-> RDY_BUSY_OE || $past(RDY_BUSY_OE))
    else $error("busy did not start");
  a_drop_quiet: assert property (CMD_DROPPED && !$past(RDY_BUSY_OE) |-> (!RDY_BUSY_OE) [*4])
    else $error("dropped command went busy");
  a_one_outcome: assert property (!(CMD_VALID && CMD_DROPPED)) else $error("both pulses");
  a_reset_idle: assert property (s_pin_reset |-> !RDY_BUSY_OE && !CMD_VALID)
    else $error("active during pin reset");
  a_busy_span: assert property ($fell(RDY_BUSY_OE) && !rst_seen |->
    busy_cnt >= BUSY_CYCLES - 1 && busy_cnt <= BUSY_CYCLES + 1) else $error("busy length");
  a_erase_kind: assert property (CMD_VALID && CMD_ERASE != 3'h0 |-> CMD_KIND == 3'h3)
    else $error("erase kind");
  a_src_kind: assert property (CMD_VALID && CMD_SRC != 2'h0 |-> CMD_KIND == 3'h1)
    else $error("read source kind");
  a_linear_byte: assert property (CMD_VALID && PAGE_512 |-> !CMD_BYTE[9])
    else $error("byte field too wide");
endmodule : sfcfe_checker
bind sfcfe_top sfcfe_checker #(.BUSY_CYCLES(BUSY_CYCLES)) sfcfe_checker_i (
  .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .CS_N(CS_N), .SO_OE(SO_OE), .RESET_N(RESET_N),
  .RDY_BUSY_O(RDY_BUSY_O), .RDY_BUSY_OE(RDY_BUSY_OE), .PAGE_512(PAGE_512),
  .CMD_VALID(CMD_VALID), .CMD_DROPPED(CMD_DROPPED), .CMD_KIND(CMD_KIND),
  .CMD_ERASE(CMD_ERASE), .CMD_SRC(CMD_SRC), .CMD_BYTE(CMD_BYTE));
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking testbench for the serial flash command front end.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import sfcfe_pkg::*;
  logic        clk, rst, wp_n, reset_n, page_512, so, so_oe, rb_o, rb_oe, v, d;
  logic        sck, cs_n, si, seen_v, seen_d, seen_b;
  logic [7:0]  rd_data, op_o, rx;
  logic [2:0]  kind, er;
  logic [1:0]  src;
  logic [12:0] page;
  logic [9:0]  byt;
  int          n_errors, cmp_count;
  wire         rb_pin = rb_oe ? rb_o : 1'b1;
  sfcfe_top #(.BUSY_CYCLES(200)) sfcfe_top_i (.CORE_CLK(clk), .SYS_RST(rst), .SCK(sck),
    .CS_N(cs_n), .SI(si), .SO(so), .SO_OE(so_oe), .WP_N(wp_n), .RESET_N(reset_n),
    .RDY_BUSY_O(rb_o), .RDY_BUSY_OE(rb_oe), .PAGE_512(page_512), .RD_DATA(rd_data),
    .CMD_VALID(v), .CMD_OPCODE(op_o), .CMD_KIND(kind), .CMD_SRC(src), .CMD_ERASE(er),
    .CMD_PAGE(page), .CMD_BYTE(byt), .CMD_DROPPED(d));
  sfcfe_host sfcfe_host_i (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (v === 1'b1) seen_v <= 1'b1;
    if (d === 1'b1) seen_d <= 1'b1;
    if (rb_pin === 1'b0) seen_b <= 1'b1;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic run(input logic [7:0] op, input logic [23:0] addr, input logic mode3);
    @(posedge clk);
    seen_v <= 1'b0;
    seen_d <= 1'b0;
    seen_b <= 1'b0;
    sfcfe_host_i.frame(op, addr, 6'd40, mode3, rx);
    repeat (12) @(posedge clk);
  endtask : run
  task automatic idle();
    for (int k = 0; k < 200 && rb_pin !== 1'b1; k++) @(posedge clk);
    chk(rb_pin, 1'b1);
  endtask : idle
  task automatic t_reads();
    logic [7:0] ops [6] = '{8'hE8, 8'h0B, 8'h03, 8'hD2, 8'hD4, 8'hD6};
    logic [1:0] srcs [6] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h3};
    for (int i = 0; i < 6; i++) begin
      run(ops[i], 24'h7FC3FF, i[0]);
      chk(seen_v, 1'b1);
      chk(op_o, ops[i]);
      chk(src, srcs[i]);
      chk(rx, rd_data);
      chk({page, byt}, {13'h1FF0, 10'h3FF});
    end
    run(8'h03, 24'h000000, 1'b0);
    chk(rx, rd_data);
    page_512 <= 1'b1;
    run(8'h03, 24'h3FFE01, 1'b1);
    chk({page, byt}, {13'h1FFF, 10'h001});
    page_512 <= 1'b0;
    $display("reads finished");
  endtask : t_reads
  task automatic t_busy();
    logic [7:0] ops [7] = '{8'h81, 8'h50, 8'h7C, 8'hC7, 8'h83, 8'h53, 8'h60};
    logic [2:0] kinds [7] = '{3'h3, 3'h3, 3'h3, 3'h3, 3'h2, 3'h4, 3'h5};
    logic [2:0] ers [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0, 3'h0, 3'h0};
    for (int i = 0; i < 7; i++) begin
      run(ops[i], 24'h001200, i[0]);
      chk({kind, er}, {kinds[i], ers[i]});
      chk(seen_b, 1'b1);
      idle();
    end
    $display("busy operations finished");
  endtask : t_busy
  task automatic t_protect();
    wp_n <= 1'b0;
    repeat (8) @(posedge clk);
    run(8'h83, 24'h000100, 1'b0);
    chk({seen_v, seen_d, seen_b}, 3'b010);
    run(8'h3D, 24'h2A7FFC, 1'b1);
    chk({seen_v, seen_d, seen_b}, 3'b010);
    for (int i = 0; i < 2; i++) begin
      run(8'h3D, i ? 24'h2A7F30 : 24'h2A7FA9, i[0]);
      chk({seen_v, kind}, {1'b1, 3'h6});
      idle();
    end
    wp_n <= 1'b1;
    $display("protection finished");
  endtask : t_protect
  task automatic t_reset();
    run(8'hC7, 24'h000000, 1'b0);
    reset_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk(rb_pin, 1'b1);
    run(8'hD4, 24'h000000, 1'b0);
    chk(seen_v, 1'b0);
    reset_n <= 1'b1;
    fork
      run(8'hD2, 24'h000000, 1'b1);
      begin
        repeat (60) @(posedge clk);
        reset_n <= 1'b0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
      end
    join
    chk({seen_v, seen_d}, 2'b00);
    run(8'hD6, 24'h000000, 1'b0);
    chk({seen_v, src}, {1'b1, 2'h3});
    $display("reset finished");
  endtask : t_reset
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  initial begin
    #400000;
    n_errors++;
    stop_test();
  end
  initial begin
    {rst, wp_n, reset_n, page_512, seen_v, seen_d, seen_b} = 7'b1110000;
    rd_data = 8'hA6;
    n_errors = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reads();
    t_busy();
    t_protect();
    t_reset();
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
